// ### design/acc_ctrl.sv
// Our own choices: the APB slave port and the register offsets.
`default_nettype none
module acc_ctrl import acc_pkg::*; #(
  parameter int unsigned DEB_CYC    = DEBOUNCE_CYC,
  parameter int unsigned FLASH_HALF = FLASH_CYC
) (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [11:0]            paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic [NUM_DED_IN-1:0]  alm_in_i,
  input  wire logic [NUM_CFG_IO-1:0]  cio_i,
  output logic      [NUM_CFG_IO-1:0]  cio_o,
  output logic      [NUM_CFG_IO-1:0]  cio_oe_n_o,
  input  wire logic [NUM_EXP_IN-1:0]  exp_in_i,
  input  wire logic                   exp_present_i,
  output logic      [NUM_EXP_OUT-1:0] exp_out_o,
  input  wire logic                   supply_a_ok_i,
  input  wire logic                   supply_b_ok_i,
  input  wire logic                   local_ring_i,
  input  wire logic                   express_ring_i,
  output logic                        fail_led_o,
  output logic                        provisioned_indicator_o,
  output acc_bicolor_s                supply_a_indicator_o,
  output acc_bicolor_s                supply_b_indicator_o,
  output logic                        input_led_o,
  output logic                        output_led_o,
  output logic                        local_ring_led_o,
  output logic                        express_voice_channel_ring_led_o
);
  localparam int unsigned NPIN = NUM_IN + 5;
  localparam int unsigned DA_W = $clog2(NUM_IN * DESC_LEN);

  typedef struct packed {
    acc_in_cfg_s  [NUM_IN-1:0]  in_cfg;
    acc_out_cfg_s [NUM_OUT-1:0] out_cfg;
    acc_ctrl_s                  ctrl;
    acc_sys_alm_s               sys_alm;
    logic [NUM_IN-1:0]          cond;
    logic [NUM_IN-1:0]          act;
    logic [NUM_OUT-1:0]         out;
    logic [4:0]                 dsel;
    logic [5:0]                 didx;
    logic [31:0]                flash_cnt;
    logic                       flash;
    logic                       fail;
    logic                       prov;
    logic                       in_led;
    logic                       out_led;
    logic                       lring;
    logic                       xring;
    acc_bicolor_s               sup_a;
    acc_bicolor_s               sup_b;
    logic [31:0]                prdata;
  } acc_state_s;

  localparam acc_state_s ST_RST = '{
    in_cfg:  {NUM_IN{IN_CFG_RST}},
    out_cfg: {NUM_OUT{OUT_CFG_RST}},
    ctrl:    CTRL_RST,
    fail:    1'b1,
    // Supplies read as out of range until their filtered pins say otherwise
    sup_a:   2'h1,
    sup_b:   2'h1,
    default: '0
  };

  acc_state_s         st_q, st_d;
  logic [NPIN-1:0]    pin_raw;
  logic [NPIN-1:0]    pin_deb;
  logic [NUM_IN-1:0]  in_valid;
  logic [NUM_IN-1:0]  cond_c;
  logic [NUM_IN-1:0]  in_wr;
  logic [NUM_VW-1:0]  vw;
  logic [7:0]         hit_loc;
  logic [7:0]         hit_rem;
  logic               wr_acc;
  logic               rd_setup;
  logic               in_hit;
  logic               out_hit;
  logic               known;
  logic [31:0]        rdata;
  logic [DA_W-1:0]    desc_addr;
  logic [7:0]         desc_q [NUM_IN*DESC_LEN];

  // Every contact, ring and supply pin goes through the same filter
  assign pin_raw = {express_ring_i, local_ring_i, supply_b_ok_i, supply_a_ok_i,
                    exp_present_i, exp_in_i, cio_i, alm_in_i};

  for (genvar g = 0; g < NPIN; g++) begin : g_deb
    acc_debounce #(.CYC(DEB_CYC)) u_deb (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (pin_raw[g]),
      .level_o   (pin_deb[g])
    );
  end

  // APB decode; writes land in the access phase, read data is taken in setup
  assign wr_acc   = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign in_hit   = paddr_i[11:7] == REG_IN_CFG[11:7] && paddr_i[1:0] == 2'h0;
  assign out_hit  = paddr_i[11:6] == REG_OUT_CFG[11:6] && paddr_i[1:0] == 2'h0;
  assign known    = in_hit | out_hit | paddr_i == REG_CTRL | paddr_i == REG_IN_ALM
                  | paddr_i == REG_OUT_ST | paddr_i == REG_VW | paddr_i == REG_SYS_ALM
                  | paddr_i == REG_DESC_PTR | paddr_i == REG_DESC_DATA;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~known;
  assign desc_addr = DA_W'(st_q.dsel * DESC_LEN + st_q.didx);

  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      in_wr[i] = wr_acc && in_hit && paddr_i[6:2] == 5'(i);
      if (i < NUM_DED_IN) begin
        in_valid[i] = 1'b1;
      end else if (i < NUM_DED_IN + NUM_CFG_IO) begin
        in_valid[i] = ~st_q.ctrl.io_dir[i - NUM_DED_IN];
      end else begin
        in_valid[i] = pin_deb[NUM_IN];
      end
      cond_c[i] = in_valid[i] &
                  (st_q.in_cfg[i].alm_on_close ? pin_deb[i] : ~pin_deb[i]);
    end
  end

  // Threshold hits: index t is true when an alarm of rank t or higher exists
  always_comb begin
    vw = '0;
    for (int t = 0; t < 8; t++) begin
      hit_loc[t] = st_q.sys_alm.loc_present && st_q.sys_alm.loc_sev >= 3'(t);
      hit_rem[t] = st_q.sys_alm.rem_present && st_q.sys_alm.rem_sev >= 3'(t);
      for (int i = 0; i < NUM_IN; i++) begin
        if (st_q.act[i] && st_q.in_cfg[i].sev >= 3'(t)) begin
          hit_loc[t] = 1'b1;
        end
      end
    end
    for (int i = 0; i < NUM_IN; i++) begin
      if (st_q.act[i] && st_q.in_cfg[i].vw_en) begin
        vw[st_q.in_cfg[i].vw_sel] = 1'b1;
      end
    end
  end

  always_comb begin
    rdata = '0;
    if (in_hit) begin
      // Severity and class are read back with the live alarm bit
      rdata = {23'h0, st_q.act[paddr_i[6:2]], st_q.in_cfg[paddr_i[6:2]]};
    end else if (out_hit) begin
      rdata = {22'h0, st_q.out[paddr_i[5:2]], st_q.out_cfg[paddr_i[5:2]]};
    end else begin
      case (paddr_i)
        REG_CTRL:      rdata = {25'h0, st_q.ctrl};
        REG_IN_ALM:    rdata = st_q.act;
        REG_OUT_ST:    rdata = {16'h0, st_q.out};
        REG_VW:        rdata = {28'h0, vw};
        REG_SYS_ALM:   rdata = {24'h0, st_q.sys_alm};
        REG_DESC_PTR:  rdata = {18'h0, st_q.didx, 3'h0, st_q.dsel};
        REG_DESC_DATA: rdata = st_q.didx < 6'(DESC_LEN) ? {24'h0, desc_q[desc_addr]} : 32'h0;
        default:       rdata = '0;
      endcase
    end
  end

  always_comb begin
    st_d = st_q;
    for (int i = 0; i < NUM_IN; i++) begin
      st_d.cond[i] = cond_c[i];
      // A new event wins over a clear in the same cycle
      if (cond_c[i] && !st_q.cond[i]) begin
        st_d.act[i] = 1'b1;
      end else if (!cond_c[i] || in_wr[i]) begin
        st_d.act[i] = 1'b0;
      end
    end
    for (int j = 0; j < NUM_OUT; j++) begin
      case (st_q.out_cfg[j].frc)
        FRC_CLOSE: st_d.out[j] = 1'b1;
        FRC_OPEN:  st_d.out[j] = 1'b0;
        default: begin
          case (st_q.out_cfg[j].mode)
            MODE_LOCAL:  st_d.out[j] = hit_loc[st_q.out_cfg[j].thr];
            MODE_REMOTE: st_d.out[j] = hit_rem[st_q.out_cfg[j].thr];
            MODE_VWIRE:  st_d.out[j] = vw[st_q.out_cfg[j].vw_sel];
            default:     st_d.out[j] = 1'b0;
          endcase
        end
      endcase
      // A contact set as input, or a missing panel, keeps the output open
      if (j < NUM_CFG_IO) begin
        st_d.out[j] = st_d.out[j] & st_q.ctrl.io_dir[j];
      end else begin
        st_d.out[j] = st_d.out[j] & pin_deb[NUM_IN];
      end
    end
    if (st_q.flash_cnt >= FLASH_HALF - 1) begin
      st_d.flash_cnt = '0;
      st_d.flash     = ~st_q.flash;
    end else begin
      st_d.flash_cnt = st_q.flash_cnt + 32'h1;
    end
    st_d.fail    = st_q.ctrl.booting ? st_q.flash : ~st_q.ctrl.proc_ready;
    st_d.prov    = st_q.ctrl.provisioned;
    st_d.in_led  = |st_q.act;
    st_d.out_led = |st_q.out;
    st_d.lring   = pin_deb[NUM_IN + 3] & st_q.flash;
    st_d.xring   = pin_deb[NUM_IN + 4] & st_q.flash;
    st_d.sup_a   = '{green: pin_deb[NUM_IN + 1], red: ~pin_deb[NUM_IN + 1]};
    st_d.sup_b   = '{green: pin_deb[NUM_IN + 2], red: ~pin_deb[NUM_IN + 2]};
    if (rd_setup) begin
      st_d.prdata = rdata;
    end
    if (wr_acc) begin
      if (in_hit) begin
        st_d.in_cfg[paddr_i[6:2]] = pwdata_i[7:0];
      end else if (out_hit) begin
        st_d.out_cfg[paddr_i[5:2]] = pwdata_i[8:0];
      end else begin
        case (paddr_i)
          REG_CTRL:     st_d.ctrl    = pwdata_i[6:0];
          REG_SYS_ALM:  st_d.sys_alm = pwdata_i[7:0];
          REG_DESC_PTR: begin
            st_d.dsel = pwdata_i[4:0];
            st_d.didx = pwdata_i[13:8];
          end
          REG_DESC_DATA: begin
            // Pointer walks on so a text loads as a run of writes
            if (st_q.didx < 6'(DESC_LEN)) begin
              st_d.didx = st_q.didx + 6'h1;
            end
          end
          default: st_d.ctrl = st_q.ctrl;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Text storage has no reset: software always loads it before use
  always_ff @(posedge clk_i) begin
    if (wr_acc && paddr_i == REG_DESC_DATA && st_q.didx < 6'(DESC_LEN)) begin
      desc_q[desc_addr] <= pwdata_i[7:0];
    end
  end

  assign prdata_o                         = st_q.prdata;
  assign cio_o                            = st_q.out[NUM_CFG_IO-1:0];
  assign cio_oe_n_o                       = ~st_q.ctrl.io_dir;
  assign exp_out_o                        = st_q.out[NUM_OUT-1:NUM_CFG_IO];
  assign fail_led_o                       = st_q.fail;
  assign provisioned_indicator_o          = st_q.prov;
  assign supply_a_indicator_o             = st_q.sup_a;
  assign supply_b_indicator_o             = st_q.sup_b;
  assign input_led_o                      = st_q.in_led;
  assign output_led_o                     = st_q.out_led;
  assign local_ring_led_o                 = st_q.lring;
  assign express_voice_channel_ring_led_o = st_q.xring;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_cfg0_write;
    psel_i && penable_i && pwrite_i && paddr_i == REG_IN_CFG;
  endsequence
  sequence s_no_rise0;
    !(cond_c[0] && !st_q.cond[0]);
  endsequence

  a_alarm_release: assert property (s_cfg0_write ##0 s_no_rise0 |=> !st_q.act[0])
    else $error("input alarm not released by reprovisioning");
  a_alarm_hold: assert property (st_q.act[0] && cond_c[0] && !in_wr[0] |=> st_q.act[0])
    else $error("input alarm dropped while condition held");
  a_polarity_eval: assert property (cond_c[0] == (st_q.in_cfg[0].alm_on_close == pin_deb[0]))
    else $error("input polarity evaluated wrongly");
  a_force_close: assert property (st_q.out_cfg[0].frc == FRC_CLOSE && st_q.ctrl.io_dir[0]
    |=> st_q.out[0])
    else $error("forced close did not close output");
  a_force_open: assert property (st_q.out_cfg[0].frc == FRC_OPEN |=> !st_q.out[0])
    else $error("forced open did not open output");
  a_local_trig: assert property (st_q.out_cfg[0].frc == FRC_NONE
    && st_q.out_cfg[0].mode == MODE_LOCAL && st_q.ctrl.io_dir[0] && st_q.sys_alm.loc_present
    && st_q.sys_alm.loc_sev >= st_q.out_cfg[0].thr |=> st_q.out[0])
    else $error("local threshold did not close output");
  a_vwire_map: assert property (st_q.act[0] && st_q.in_cfg[0].vw_en |-> vw[st_q.in_cfg[0].vw_sel])
    else $error("virtual wire not raised by mapped alarm");
  a_input_led: assert property ((|st_q.act) |=> input_led_o)
    else $error("input summary not lit");
  a_output_led: assert property (!(|st_q.out) |=> !output_led_o)
    else $error("output summary lit with all outputs open");
  a_fail_ready: assert property (!st_q.ctrl.booting && !st_q.ctrl.proc_ready |=> fail_led_o)
    else $error("fail indicator dark while processor not ready");
  a_prov_led: assert property ($rose(st_q.ctrl.provisioned) |=> provisioned_indicator_o)
    else $error("provisioned indicator not lit");
  a_supply_color: assert property (supply_a_indicator_o.green != supply_a_indicator_o.red)
    else $error("supply indicator shows both or no colour");
endmodule
`default_nettype wire

// ### design/acc_pkg.sv
`default_nettype none
package acc_pkg;
  localparam int unsigned CLK_MHZ     = 250;
  localparam int unsigned DEBOUNCE_US = 1000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned FLASH_MS    = 250;
  localparam int unsigned FLASH_CYC   = FLASH_MS * CLK_MHZ * 1000;

  localparam int unsigned NUM_DED_IN  = 12;
  localparam int unsigned NUM_CFG_IO  = 4;
  localparam int unsigned NUM_EXP_IN  = 16;
  localparam int unsigned NUM_EXP_OUT = 12;
  localparam int unsigned NUM_IN      = NUM_DED_IN + NUM_CFG_IO + NUM_EXP_IN;
  localparam int unsigned NUM_OUT     = NUM_CFG_IO + NUM_EXP_OUT;
  localparam int unsigned NUM_VW      = 4;
  localparam int unsigned DESC_LEN    = 63;

  localparam logic [11:0] REG_CTRL      = 12'h000;
  localparam logic [11:0] REG_IN_ALM    = 12'h004;
  localparam logic [11:0] REG_OUT_ST    = 12'h008;
  localparam logic [11:0] REG_VW        = 12'h00c;
  localparam logic [11:0] REG_SYS_ALM   = 12'h010;
  localparam logic [11:0] REG_DESC_PTR  = 12'h014;
  localparam logic [11:0] REG_DESC_DATA = 12'h018;
  localparam logic [11:0] REG_IN_CFG    = 12'h100;
  localparam logic [11:0] REG_OUT_CFG   = 12'h200;

  localparam logic [2:0] SEV_NR   = 3'h0;
  localparam logic [2:0] SEV_NA   = 3'h1;
  localparam logic [2:0] SEV_MIN  = 3'h2;
  localparam logic [2:0] SEV_MAJ  = 3'h3;
  localparam logic [2:0] SEV_CRIT = 3'h4;

  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_LOCAL  = 2'h1;
  localparam logic [1:0] MODE_REMOTE = 2'h2;
  localparam logic [1:0] MODE_VWIRE  = 2'h3;
  localparam logic [1:0] FRC_NONE    = 2'h0;
  localparam logic [1:0] FRC_OPEN    = 2'h1;
  localparam logic [1:0] FRC_CLOSE   = 2'h2;

  typedef struct packed {
    logic [1:0] vw_sel;
    logic       vw_en;
    logic       svc_aff;
    logic [2:0] sev;
    logic       alm_on_close;
  } acc_in_cfg_s;

  typedef struct packed {
    logic [1:0] frc;
    logic [1:0] vw_sel;
    logic [2:0] thr;
    logic [1:0] mode;
  } acc_out_cfg_s;

  typedef struct packed {
    logic [3:0] io_dir;
    logic       booting;
    logic       proc_ready;
    logic       provisioned;
  } acc_ctrl_s;

  typedef struct packed {
    logic       rem_present;
    logic [2:0] rem_sev;
    logic       loc_present;
    logic [2:0] loc_sev;
  } acc_sys_alm_s;

  typedef struct packed {
    logic green;
    logic red;
  } acc_bicolor_s;

  localparam acc_in_cfg_s  IN_CFG_RST  = 8'h03;
  localparam acc_out_cfg_s OUT_CFG_RST = 9'h000;
  localparam acc_ctrl_s    CTRL_RST    = 7'h04;
endpackage
`default_nettype wire

// ### design/acc_debounce.sv
`default_nettype none
module acc_debounce import acc_pkg::*; #(
  parameter int unsigned CYC = DEBOUNCE_CYC
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      level_o
);
  localparam int unsigned CW = $clog2(CYC + 1);

  typedef struct packed {
    logic [2:0]    sync;
    logic [CW-1:0] cnt;
    logic          level;
  } acc_deb_s;

  acc_deb_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[1:0], pin_i};
    // A change is only seen once stages two and three agree
    if (st_q.sync[1] == st_q.sync[2] && st_q.sync[2] != st_q.level) begin
      if (st_q.cnt == CW'(CYC - 1)) begin
        st_d.level = st_q.sync[2];
        st_d.cnt   = '0;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end else begin
      st_d.cnt = '0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.level;

  a_stable_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $changed(st_q.level) |-> $past(st_q.cnt) == CW'(CYC - 1))
    else $error("debounced level changed before stable count");
endmodule
`default_nettype wire

// ### test/acc_contact_model.sv
`default_nettype none
module acc_contact_model (
  input  wire logic        clk_i,
  input  wire logic [11:0] lvl_i,
  input  wire logic [3:0]  ext_cio_i,
  input  wire logic [3:0]  cio_o_i,
  input  wire logic [3:0]  cio_oe_n_i,
  output logic      [11:0] alm_in_o,
  output logic      [3:0]  cio_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] seen_q = 12'h000;
  logic [11:0] chg_q  = 12'h000;
  logic [2:0]  bnc_q  = 3'h0;

  initial alm_in_o = 12'h000;

  // Real contacts chatter: changed bits toggle every cycle for a while before settling
  always @(posedge clk_i) begin
    if (lvl_i != seen_q) begin
      chg_q  <= lvl_i ^ seen_q;
      seen_q <= lvl_i;
      bnc_q  <= 3'h3;
    end else if (bnc_q != 3'h0) begin
      bnc_q <= bnc_q - 3'h1;
    end
    alm_in_o <= (bnc_q != 3'h0) ? (alm_in_o ^ chg_q) : seen_q;
  end

  // Shared wire: the card's own drive wins where its enable is low
  assign cio_in_o = (cio_oe_n_i & ext_cio_i) | (~cio_oe_n_i & cio_o_i);
endmodule
`default_nettype wire

// ### test/acc_ctrl_tb.sv
`default_nettype none
module acc_ctrl_tb import acc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] icfg;
    logic [8:0] ocfg;
    logic       pin;
    logic       alm;
    logic       out;
  } acc_row_s;
  logic         clk_i = 1'b0, sys_rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic         supa = 1'b0, supb = 1'b0, lring = 1'b0, xring = 1'b0, err, exp_pres = 1'b0;
  logic [11:0]  paddr = 12'h000, contacts = 12'h000, alm_pins, exp_out;
  logic [15:0]  exp_in = 16'h0000;
  logic [31:0]  pwdata = 32'h0, rd, prdata;
  logic [3:0]   ext_cio = 4'h0, cio_in, cio_out, cio_oe_n;
  logic         pready, pslverr, fail, prov, in_led, out_led, lr_led, xr_led;
  acc_bicolor_s sa, sb;
  int           err_count = 0, samples_checked = 0, f, l, x;
  acc_row_s     rows [10] = '{
    '{8'h05, 9'h009, 1'b1, 1'b1, 1'b1}, '{8'h07, 9'h011, 1'b1, 1'b1, 1'b0},
    '{8'h19, 9'h00d, 1'b1, 1'b1, 1'b1}, '{8'h04, 9'h009, 1'b1, 1'b0, 1'b0},
    '{8'h04, 9'h009, 1'b0, 1'b1, 1'b1}, '{8'ha5, 9'h043, 1'b1, 1'b1, 1'b1},
    '{8'ha5, 9'h023, 1'b1, 1'b1, 1'b0}, '{8'h09, 9'h00a, 1'b1, 1'b1, 1'b0},
    '{8'h09, 9'h089, 1'b1, 1'b1, 1'b0}, '{8'h05, 9'h100, 1'b0, 1'b0, 1'b1}};

  always #2 clk_i = ~clk_i;

  acc_contact_model u_model (.clk_i(clk_i), .lvl_i(contacts), .ext_cio_i(ext_cio), .cio_o_i(cio_out),
    .cio_oe_n_i(cio_oe_n), .alm_in_o(alm_pins), .cio_in_o(cio_in));

  // Short counts keep the run brief; the debounce and flash waits below are sized from these
  acc_ctrl #(.DEB_CYC(4), .FLASH_HALF(8)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .alm_in_i(alm_pins), .cio_i(cio_in), .cio_o(cio_out), .cio_oe_n_o(cio_oe_n), .exp_in_i(exp_in),
    .exp_present_i(exp_pres), .exp_out_o(exp_out), .supply_a_ok_i(supa), .supply_b_ok_i(supb),
    .local_ring_i(lring), .express_ring_i(xring), .fail_led_o(fail), .provisioned_indicator_o(prov),
    .supply_a_indicator_o(sa), .supply_b_indicator_o(sb), .input_led_o(in_led), .output_led_o(out_led),
    .local_ring_led_o(lr_led), .express_voice_channel_ring_led_o(xr_led));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // Only the watchdog ends a stalled access
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Counts level changes of the fail and both ring lamps over 40 cycles
  task automatic flashes(output int cf, output int cl, output int cx);
    logic pf, pl, px;
    cf = 0; cl = 0; cx = 0; pf = fail; pl = lr_led; px = xr_led;
    repeat (40) begin
      @(negedge clk_i);
      cf += int'(fail !== pf); cl += int'(lr_led !== pl); cx += int'(xr_led !== px);
      pf = fail; pl = lr_led; px = xr_led;
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    wt(19);
    check({fail, prov, cio_oe_n, pready}, 7'h5f);
    @(posedge clk_i) sys_rst_i <= 1'b0;
    flashes(f, l, x);
    check({31'h0, f > 2}, 32'h1);
    check({sa, sb}, 4'h5);
    apb(1'b0, REG_CTRL, 32'h0);     check(rd, 32'h4);
    apb(1'b0, REG_IN_CFG + 12'h014, 32'h0); check(rd, 32'h3);
    apb(1'b0, REG_OUT_CFG + 12'h00c, 32'h0); check(rd, 32'h0);
    apb(1'b0, 12'h800, 32'h0);      check({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h001, 32'h0);      check({31'h0, err}, 32'h1);
    apb(1'b1, REG_CTRL, 32'h79);
    wt(2);
    check(fail, 1'b1);
    apb(1'b1, REG_CTRL, 32'h7b);
    wt(2);
    check({fail, prov}, 2'h1);
    supa <= 1'b1;
    wt(20);
    check({sa, sb}, 4'h9);
    foreach (rows[i]) begin
      contacts[0] <= ~rows[i].pin;
      wt(30);
      apb(1'b1, REG_IN_CFG, {24'h0, rows[i].icfg});
      apb(1'b1, REG_OUT_CFG, {23'h0, rows[i].ocfg});
      contacts[0] <= rows[i].pin;
      wt(30);
      apb(1'b0, REG_IN_ALM, 32'h0); check(rd, {31'h0, rows[i].alm});
      apb(1'b0, REG_IN_CFG, 32'h0); check(rd, {23'h0, rows[i].alm, rows[i].icfg});
      apb(1'b0, REG_OUT_ST, 32'h0); check(rd, {31'h0, rows[i].out});
      check({in_led, out_led, cio_out[0], cio_oe_n[0], exp_out}, {rows[i].alm, {2{rows[i].out}}, 13'h0});
    end
    apb(1'b1, REG_SYS_ALM, 32'hbb);
    apb(1'b1, REG_OUT_CFG, 32'h011); apb(1'b0, REG_OUT_ST, 32'h0); check(rd, 32'h0);
    apb(1'b1, REG_OUT_CFG, 32'h00d); apb(1'b0, REG_OUT_ST, 32'h0); check(rd, 32'h1);
    apb(1'b1, REG_OUT_CFG, 32'h00a); apb(1'b0, REG_OUT_ST, 32'h0); check(rd, 32'h1);
    apb(1'b1, REG_OUT_CFG, 32'h012); apb(1'b0, REG_OUT_ST, 32'h0); check(rd, 32'h0);
    apb(1'b1, REG_IN_CFG, 32'h05);
    contacts[0] <= 1'b1;
    wt(2);
    contacts[0] <= 1'b0;
    wt(30);
    apb(1'b0, REG_IN_ALM, 32'h0); check(rd, 32'h0);
    contacts[0] <= 1'b1;
    wt(30);
    apb(1'b0, REG_IN_ALM, 32'h0); check(rd, 32'h1);
    apb(1'b1, REG_IN_CFG, 32'h05);
    apb(1'b0, REG_IN_ALM, 32'h0); check(rd, 32'h0);
    apb(1'b1, REG_CTRL, 32'h03);
    contacts[0] <= 1'b0;
    ext_cio <= 4'h1;
    wt(30);
    apb(1'b0, REG_IN_ALM, 32'h0); check(rd, 32'h1000);
    check(cio_oe_n, 4'hf);
    apb(1'b1, REG_OUT_CFG + 12'h010, 32'h100);
    exp_in <= 16'h0001;
    wt(30);
    check(exp_out, 12'h000);
    apb(1'b0, REG_IN_ALM, 32'h0); check(rd, 32'h1000);
    exp_pres <= 1'b1;
    wt(30);
    check(exp_out, 12'h001);
    apb(1'b0, REG_IN_ALM, 32'h0); check(rd, 32'h11000);
    apb(1'b1, REG_DESC_PTR, 32'h3e02);
    apb(1'b1, REG_DESC_DATA, 32'h41);
    apb(1'b0, REG_DESC_PTR, 32'h0); check(rd, 32'h3f02);
    apb(1'b1, REG_DESC_PTR, 32'h3e02);
    apb(1'b0, REG_DESC_DATA, 32'h0); check(rd, 32'h41);
    lring <= 1'b1;
    wt(20);
    flashes(f, l, x);
    check({30'h0, l > 2, x == 0}, 32'h3);
    lring <= 1'b0;
    xring <= 1'b1;
    wt(20);
    flashes(f, l, x);
    check({30'h0, l == 0, x > 2}, 32'h3);
    stop_test();
  end

  // The sequence needs well under 5000 cycles
  initial begin
    wt(20000);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
